//--- logic/lmd_consts.svh
// Constants for the LED driver mode and fault control block.
// Included by lmd_regmem, lmd_ctrl and the testbench; holds definitions only.
`ifndef LMD_CONSTS_SVH
`define LMD_CONSTS_SVH

`define LMD_I2C_ADDR      7'h36
`define LMD_FAULT_REG     8'h17
`define LMD_RW_LOW_LAST   8'h16
`define LMD_RW_HIGH_FIRST 8'h19
`define LMD_RW_HIGH_LAST  8'h1A
`define LMD_REG_DEPTH     27
`define LMD_NVM_RESET     8'h00
`define LMD_BITS_PER_BYTE 4'h8

`endif

//--- logic/lmd_pkg.sv
// Types shared by the LED driver control block, its checks and its testbench.
// Assumes lmd_consts.svh provides the numeric constants.
package lmd_pkg;

  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } lmd_chan_type;

  typedef struct packed {
    logic other;
    logic open_led;
    logic short_led;
  } lmd_fault_type;

  typedef enum {OWN_NONE, OWN_RED, OWN_GREEN, OWN_BLUE} lmd_owner_type;

  typedef enum {I2C_IDLE, I2C_ADDR, I2C_ACK_AW, I2C_ACK_AR, I2C_REG, I2C_ACK_REG,
                I2C_WDATA, I2C_ACK_WD, I2C_RDATA, I2C_MACK} lmd_i2c_state_type;

endpackage

//--- logic/lmd_regmem.sv
// User register array with a nonvolatile default image behind it.
// Assumes one clock; reload and store are single-cycle pulses.
`timescale 1ns/1ps
`include "lmd_consts.svh"

module lmd_regmem #(
  parameter int DEPTH = `LMD_REG_DEPTH
) (
  input  wire logic       clk,      // System clock
  input  wire logic       rst,      // Async reset, high
  input  wire logic       wr_en,    // Write strobe
  input  wire logic [4:0] wr_addr,  // Write index
  input  wire logic [7:0] wr_data,  // Write byte
  input  wire logic [4:0] rd_addr,  // Read index
  output logic      [7:0] rd_data,  // Registered read byte
  input  wire logic       reload,   // Copy image into user registers
  input  wire logic       store     // Copy user registers into image
);

  if (DEPTH < 1 || DEPTH > 32)
  begin : g_depth_check
    $error("lmd_regmem: DEPTH out of range");
  end

  logic [7:0] user_reg [DEPTH];
  logic [7:0] nvm      [DEPTH];
  logic [7:0] next_user_reg [DEPTH];
  logic [7:0] next_nvm      [DEPTH];
  logic [7:0] next_rd_data;

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      next_nvm[i]      = store ? user_reg[i] : nvm[i];
      next_user_reg[i] = reload ? nvm[i] : user_reg[i];
      if (!reload && wr_en && wr_addr == 5'(i))
      begin
        next_user_reg[i] = wr_data;
      end
    end
    next_rd_data = (int'(rd_addr) < DEPTH) ? user_reg[rd_addr] : 8'h00;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        user_reg[i] <= `LMD_NVM_RESET;
        nvm[i]      <= `LMD_NVM_RESET;
      end
      rd_data <= 8'h00;
    end
    else
    begin
      user_reg <= next_user_reg;
      nvm      <= next_nvm;
      rd_data  <= next_rd_data;
    end
  end

endmodule // lmd_regmem

//--- logic/lmd_ctrl.sv
// Mode, channel arbitration, default reload and fault alert of the LED driver.
// Assumes all inputs are asynchronous pins; SCL must be far slower than REF_CLK.
`timescale 1ns/1ps
`include "lmd_consts.svh"

module lmd_ctrl #(
  parameter logic [6:0] I2C_ADDR  = `LMD_I2C_ADDR,
  parameter int         REG_DEPTH = `LMD_REG_DEPTH
) (
  input  wire logic                  REF_CLK,     // 25 MHz clock
  input  wire logic                  RST,         // Async reset, high
  input  wire logic                  EN,          // Device enable pin
  input  wire lmd_pkg::lmd_chan_type CHAN_EN,     // Channel enable pins
  input  wire logic                  STORE_REQ,   // Store user registers to image
  input  wire lmd_pkg::lmd_fault_type FAULT_DET,  // Raw fault detector levels
  input  wire logic                  SCL,         // I2C clock pin
  input  wire logic                  SDA_IN,      // I2C data pin level
  output logic                       SDA_OUT,     // I2C data drive value, always 0
  output logic                       SDA_OE_N,    // Low pulls SDA low
  output logic                       FAULT_OUT,   // Alert drive value, always 0
  output logic                       FAULT_OE_N,  // Low pulls alert low
  output lmd_pkg::lmd_chan_type      LED_DRIVE,   // Channel driver on
  output logic                       CONV_ON,     // Power converter on
  output logic                       STANDBY,     // Enabled with no channel on
  output lmd_pkg::lmd_fault_type     FAULT_FLAGS  // Recorded fault kinds
);

  if (REG_DEPTH <= int'(`LMD_RW_HIGH_LAST) || REG_DEPTH > 32)
  begin : g_depth_check
    $error("lmd_ctrl: REG_DEPTH cannot hold the register map");
  end

  function automatic lmd_pkg::lmd_chan_type chan_of(input lmd_pkg::lmd_owner_type o);
    lmd_pkg::lmd_chan_type c;
    c = '0;
    case (o)
      lmd_pkg::OWN_RED:   c.red   = 1'b1;
      lmd_pkg::OWN_GREEN: c.green = 1'b1;
      lmd_pkg::OWN_BLUE:  c.blue  = 1'b1;
      default:            c = '0;
    endcase
    return c;
  endfunction

  // Pin synchronisers: first stage feeds only the second
  logic [9:0] sync1;
  logic [9:0] sync2;
  logic [3:0] prev;
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end
    else
    begin
      sync1 <= {EN, CHAN_EN, STORE_REQ, FAULT_DET, SCL, SDA_IN};
      sync2 <= sync1;
      prev  <= {sync2[9], sync2[5], sync2[1], sync2[0]};
    end
  end

  logic                  en_s;
  lmd_pkg::lmd_chan_type chan_s;
  lmd_pkg::lmd_fault_type fault_s;
  logic                  scl_s;
  logic                  sda_s;
  assign en_s    = sync2[9];
  assign chan_s  = sync2[8:6];
  assign fault_s = sync2[4:2];
  assign scl_s   = sync2[1];
  assign sda_s   = sync2[0];

  logic en_rise;
  logic store_rise;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  assign en_rise    = en_s & ~prev[3];
  assign store_rise = sync2[5] & ~prev[2];
  assign scl_rise   = scl_s & ~prev[1];
  assign scl_fall   = ~scl_s & prev[1];
  assign i2c_start  = scl_s & prev[1] & prev[0] & ~sda_s;
  assign i2c_stop   = scl_s & prev[1] & ~prev[0] & sda_s;

  // Channel arbitration
  lmd_pkg::lmd_owner_type owner;
  lmd_pkg::lmd_owner_type next_owner;
  always_comb
  begin
    next_owner = owner;
    if (!en_s)
    begin
      next_owner = lmd_pkg::OWN_NONE;
    end
    else if ((chan_of(owner) & chan_s) == '0)
    begin
      // Simultaneous rises resolve red, green, blue; a later rise never preempts
      if (chan_s.red)        next_owner = lmd_pkg::OWN_RED;
      else if (chan_s.green) next_owner = lmd_pkg::OWN_GREEN;
      else if (chan_s.blue)  next_owner = lmd_pkg::OWN_BLUE;
      else                   next_owner = lmd_pkg::OWN_NONE;
    end
  end

  // I2C target
  lmd_pkg::lmd_i2c_state_type st;
  lmd_pkg::lmd_i2c_state_type next_st;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] regptr;
  logic [7:0] next_regptr;
  logic       sda_oe_n_d;
  logic       next_sda_oe_n;
  logic       mack_ok;
  logic       next_mack_ok;
  logic       mem_wr;
  logic       rd_fault;
  logic [7:0] mem_rd;
  logic [7:0] rd_byte;
  logic       writable;
  lmd_pkg::lmd_fault_type fault_flags;

  assign writable = (regptr <= `LMD_RW_LOW_LAST) ||
                    (regptr >= `LMD_RW_HIGH_FIRST && regptr <= `LMD_RW_HIGH_LAST);
  always_comb
  begin
    if (regptr == `LMD_FAULT_REG)
      rd_byte = {5'h00, fault_flags};
    else if (writable)
      rd_byte = mem_rd;
    else
      rd_byte = 8'h00;
  end

  always_comb
  begin
    next_st       = st;
    next_bitcnt   = bitcnt;
    next_shreg    = shreg;
    next_regptr   = regptr;
    next_sda_oe_n = sda_oe_n_d;
    next_mack_ok  = mack_ok;
    mem_wr        = 1'b0;
    rd_fault      = 1'b0;
    // Shutdown silences the port; standby keeps it alive
    if (!en_s || i2c_stop)
    begin
      next_st       = lmd_pkg::I2C_IDLE;
      next_sda_oe_n = 1'b1;
    end
    else if (i2c_start)
    begin
      next_st       = lmd_pkg::I2C_ADDR;
      next_bitcnt   = 4'h0;
      next_sda_oe_n = 1'b1;
    end
    else
    begin
      case (st)
        lmd_pkg::I2C_ADDR, lmd_pkg::I2C_REG, lmd_pkg::I2C_WDATA:
        begin
          if (scl_rise)
          begin
            next_shreg  = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == `LMD_BITS_PER_BYTE)
          begin
            next_sda_oe_n = 1'b0;
            if (st == lmd_pkg::I2C_ADDR)
            begin
              if (shreg[7:1] == I2C_ADDR)
                next_st = shreg[0] ? lmd_pkg::I2C_ACK_AR : lmd_pkg::I2C_ACK_AW;
              else
              begin
                next_st       = lmd_pkg::I2C_IDLE;
                next_sda_oe_n = 1'b1;
              end
            end
            else if (st == lmd_pkg::I2C_REG)
            begin
              next_regptr = shreg;
              next_st     = lmd_pkg::I2C_ACK_REG;
            end
            else
            begin
              mem_wr      = writable;
              next_regptr = regptr + 8'h01;
              next_st     = lmd_pkg::I2C_ACK_WD;
            end
          end
        end
        lmd_pkg::I2C_ACK_AW, lmd_pkg::I2C_ACK_REG, lmd_pkg::I2C_ACK_WD:
        begin
          if (scl_fall)
          begin
            next_sda_oe_n = 1'b1;
            next_bitcnt   = 4'h0;
            next_st       = (st == lmd_pkg::I2C_ACK_AW) ? lmd_pkg::I2C_REG : lmd_pkg::I2C_WDATA;
          end
        end
        lmd_pkg::I2C_ACK_AR:
        begin
          if (scl_fall)
          begin
            next_shreg    = rd_byte;
            rd_fault      = (regptr == `LMD_FAULT_REG);
            next_sda_oe_n = rd_byte[7];
            next_bitcnt   = 4'h0;
            next_st       = lmd_pkg::I2C_RDATA;
          end
        end
        lmd_pkg::I2C_RDATA:
        begin
          if (scl_rise)
            next_bitcnt = bitcnt + 4'h1;
          else if (scl_fall)
          begin
            if (bitcnt == `LMD_BITS_PER_BYTE)
            begin
              next_sda_oe_n = 1'b1;
              next_st       = lmd_pkg::I2C_MACK;
            end
            else
            begin
              next_shreg    = {shreg[6:0], 1'b0};
              next_sda_oe_n = shreg[6];
            end
          end
        end
        lmd_pkg::I2C_MACK:
        begin
          if (scl_rise)
          begin
            next_mack_ok = ~sda_s;
            // Advance early so the registered read data settles before SCL falls
            if (!sda_s)
              next_regptr = regptr + 8'h01;
          end
          else if (scl_fall)
          begin
            next_bitcnt = 4'h0;
            if (mack_ok)
            begin
              next_shreg    = rd_byte;
              rd_fault      = (regptr == `LMD_FAULT_REG);
              next_sda_oe_n = rd_byte[7];
              next_st       = lmd_pkg::I2C_RDATA;
            end
            else
              next_st = lmd_pkg::I2C_IDLE;
          end
        end
        default:
          next_st = lmd_pkg::I2C_IDLE;
      endcase
    end
  end

  // Fault flags: a new fault wins over a read that clears in the same cycle
  lmd_pkg::lmd_fault_type next_fault_flags;
  always_comb
  begin
    next_fault_flags = (rd_fault ? '0 : fault_flags) | fault_s;
  end

  lmd_pkg::lmd_chan_type next_led;
  assign next_led = chan_of(next_owner);

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      owner       <= lmd_pkg::OWN_NONE;
      st          <= lmd_pkg::I2C_IDLE;
      bitcnt      <= 4'h0;
      shreg       <= 8'h00;
      regptr      <= 8'h00;
      sda_oe_n_d  <= 1'b1;
      mack_ok     <= 1'b0;
      fault_flags <= '0;
      SDA_OUT     <= 1'b0;
      FAULT_OUT   <= 1'b0;
      FAULT_OE_N  <= 1'b1;
      LED_DRIVE   <= '0;
      CONV_ON     <= 1'b0;
      STANDBY     <= 1'b0;
      FAULT_FLAGS <= '0;
    end
    else
    begin
      owner       <= next_owner;
      st          <= next_st;
      bitcnt      <= next_bitcnt;
      shreg       <= next_shreg;
      regptr      <= next_regptr;
      sda_oe_n_d  <= next_sda_oe_n;
      mack_ok     <= next_mack_ok;
      fault_flags <= next_fault_flags;
      SDA_OUT     <= 1'b0;
      FAULT_OUT   <= 1'b0;
      FAULT_OE_N  <= ~(|next_fault_flags);
      LED_DRIVE   <= next_led;
      CONV_ON     <= (next_owner != lmd_pkg::OWN_NONE);
      STANDBY     <= en_s && (next_owner == lmd_pkg::OWN_NONE);
      FAULT_FLAGS <= next_fault_flags;
    end
  end

  assign SDA_OE_N = sda_oe_n_d;

  // Store only accepted while enabled and dark; host keeps the remaining preconditions
  logic store_go;
  assign store_go = store_rise && en_s && owner == lmd_pkg::OWN_NONE;

  lmd_regmem #(
    .DEPTH (REG_DEPTH)
  ) u_regmem (
    .clk     (REF_CLK),
    .rst     (RST),
    .wr_en   (mem_wr),
    .wr_addr (regptr[4:0]),
    .wr_data (shreg),
    .rd_addr (regptr[4:0]),
    .rd_data (mem_rd),
    .reload  (en_rise),
    .store   (store_go)
  );

endmodule // lmd_ctrl

//--- tb/lmd_ctrl_props.sv
// Concurrent checks on the pins of the LED driver control block.
// Assumes binding to lmd_ctrl; every input pin but REF_CLK and RST passes two sync stages.
`timescale 1ns/1ps
module lmd_ctrl_props (
  input wire logic                   REF_CLK,     // Clock
  input wire logic                   RST,         // Async reset, high
  input wire logic                   EN,          // Enable pin
  input wire lmd_pkg::lmd_chan_type  CHAN_EN,     // Channel enables
  input wire lmd_pkg::lmd_fault_type FAULT_DET,   // Detector levels
  input wire logic                   SCL,         // I2C clock pin
  input wire logic                   SDA_OUT,     // SDA drive value
  input wire logic                   FAULT_OUT,   // Alert drive value
  input wire logic                   FAULT_OE_N,  // Alert pull
  input wire lmd_pkg::lmd_chan_type  LED_DRIVE,   // Drivers on
  input wire logic                   CONV_ON,     // Converter on
  input wire logic                   STANDBY,     // Standby flag
  input wire lmd_pkg::lmd_fault_type FAULT_FLAGS  // Sticky flags
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  AST_ONEHOT: assert property ($onehot0(LED_DRIVE))
    else $error("two channels driven");
  AST_STBY_DARK: assert property (STANDBY |-> LED_DRIVE == 3'b000 && !CONV_ON)
    else $error("drive on in standby");
  AST_IDLE: assert property ((EN && CHAN_EN == 3'b000) [*5] |-> STANDBY && LED_DRIVE == 3'b000)
    else $error("no standby while idle");
  AST_SHUTDOWN: assert property ((!EN) [*4] |-> LED_DRIVE == 3'b000 && !STANDBY && !CONV_ON)
    else $error("active while enable low");
  // Stable window keeps owner changes from the sync delay out
  AST_LIGHT: assert property (($stable(CHAN_EN) && EN && CHAN_EN != 3'b000) [*6]
    |-> CONV_ON && LED_DRIVE != 3'b000 && (LED_DRIVE & ~CHAN_EN) == 3'b000)
    else $error("channel not lit by its own enable");
  AST_KEEP: assert property ((EN && (LED_DRIVE & CHAN_EN) != 3'b000) [*4]
    |=> LED_DRIVE == $past(LED_DRIVE))
    else $error("owner lost its drive");
  AST_FAULT: assert property (($stable(FAULT_DET) && FAULT_DET != 3'b000) [*4]
    |-> (FAULT_FLAGS & FAULT_DET) == FAULT_DET && !FAULT_OE_N)
    else $error("fault not recorded");
  // A clear needs an SCL fall first, so a long high SCL forbids any flag dropping
  AST_HOLD: assert property ((FAULT_FLAGS != 3'b000 && SCL) [*6]
    |=> (FAULT_FLAGS & $past(FAULT_FLAGS)) == $past(FAULT_FLAGS))
    else $error("flag dropped without a read");
  AST_ALERT: assert property (FAULT_FLAGS != 3'b000 |-> !FAULT_OE_N)
    else $error("alert released with flags set");
  AST_RELEASE: assert property ($rose(FAULT_OE_N) |-> FAULT_FLAGS == 3'b000)
    else $error("alert released before clear");
  AST_OD: assert property (SDA_OUT == 1'b0 && FAULT_OUT == 1'b0)
    else $error("open-drain value high");
endmodule // lmd_ctrl_props

bind lmd_ctrl lmd_ctrl_props u_props (.REF_CLK(REF_CLK), .RST(RST), .EN(EN), .CHAN_EN(CHAN_EN),
  .FAULT_DET(FAULT_DET), .SCL(SCL), .SDA_OUT(SDA_OUT), .FAULT_OUT(FAULT_OUT), .FAULT_OE_N(FAULT_OE_N),
  .LED_DRIVE(LED_DRIVE), .CONV_ON(CONV_ON), .STANDBY(STANDBY), .FAULT_FLAGS(FAULT_FLAGS));

//--- tb/lmd_host.sv
// Host controller model: I2C master on an open-drain SDA line.
// Assumes a pull-up on SDA; high phases span seven clocks and low phases eight, above the target's minimum.
`timescale 1ns/1ps
module lmd_host #(
  parameter logic [6:0] ADDR = 7'h36
) (
  input  wire logic clk,  // Bench clock
  input  wire logic sda,  // Resolved SDA level
  output logic      scl,  // Host SCL level
  output logic      sdo   // Host SDA, low pulls
);
  initial
  begin
    scl = 1'b1;
    sdo = 1'b1;
  end

  task automatic ph(input logic c, input logic d, input int n);
    @(posedge clk);
    scl <= c;
    sdo <= d;
    repeat (n) @(posedge clk);
  endtask

  // Data moves only mid-low phase, never with the SCL edge
  task automatic bit_io(input logic b, output logic s);
    ph(1'b0, sdo, 3);
    ph(1'b0, b, 3);
    ph(1'b1, b, 6);
    s = sda;
  endtask

  task automatic start();
    ph(1'b0, sdo, 3);
    ph(1'b0, 1'b1, 3);
    ph(1'b1, 1'b1, 6);
    ph(1'b1, 1'b0, 6);
  endtask

  task automatic stop();
    ph(1'b0, sdo, 3);
    ph(1'b0, 1'b0, 3);
    ph(1'b1, 1'b0, 6);
    ph(1'b1, 1'b1, 6);
  endtask

  task automatic put(input logic [7:0] d, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ok = ok & !s;
  endtask

  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    put({dev, 1'b0}, ok);
    put(r, ok);
    put(d, ok);
    stop();
  endtask

  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    logic ok;
    ok = 1'b1;
    start();
    put({ADDR, 1'b0}, ok);
    put(r, ok);
    start();
    put({ADDR, 1'b1}, ok);
    get(1'b1, d);
    stop();
  endtask
endmodule // lmd_host

//--- tb/tb_lmd_ctrl.sv
// Testbench of the LED driver control block: pins and I2C register port.
// Assumes lmd_host as the host; SDA resolved with a pull-up.
`timescale 1ns/1ps
`include "lmd_consts.svh"
`define CHK(a, e) \
  begin \
    cmp_count++; \
    if ((a) !== (e)) \
    begin \
      n_fail++; \
      $display("[ERR] %0t got %h want %h", $time, (a), (e)); \
    end \
  end
module tb_lmd_ctrl;
  logic                   ref_clk = 1'b0;
  logic                   rst, en, store_req, scl, sdo, ok;
  logic                   sda_out, sda_oe_n, fault_out, fault_oe_n, conv_on, standby;
  lmd_pkg::lmd_chan_type  chan_en, led_drive;
  lmd_pkg::lmd_fault_type fault_det, fault_flags;
  logic [7:0]             d;
  logic [7:0]             ra [4] = '{8'h00, 8'h16, 8'h19, 8'h1A};
  int                     n_fail = 0;
  int                     cmp_count = 0;
  wire                    sda = sdo & sda_oe_n;

  always #20 ref_clk = ~ref_clk;

  lmd_ctrl DUT (.REF_CLK(ref_clk), .RST(rst), .EN(en), .CHAN_EN(chan_en), .STORE_REQ(store_req),
    .FAULT_DET(fault_det), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
    .FAULT_OUT(fault_out), .FAULT_OE_N(fault_oe_n), .LED_DRIVE(led_drive), .CONV_ON(conv_on),
    .STANDBY(standby), .FAULT_FLAGS(fault_flags));
  lmd_host HOST (.clk(ref_clk), .sda(sda), .scl(scl), .sdo(sdo));

  task automatic end_of_test();
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk_rd(input logic [7:0] r, input logic [7:0] e);
    HOST.rd(r, d);
    `CHK(d, e)
  endtask

  task automatic chan(input logic [2:0] c, input logic [4:0] e);
    chan_en <= c;
    cyc(6);
    `CHK({led_drive, conv_on, standby}, e)
  endtask

  initial
  begin
    cyc(60000);
    n_fail++;
    end_of_test();
  end

  initial
  begin
    rst = 1'b1;
    en = 1'b0;
    store_req = 1'b0;
    chan_en = 3'b000;
    fault_det = 3'b000;
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    en <= 1'b1;
    cyc(8);
    `CHK({led_drive, conv_on, standby}, 5'b000_0_1)
    chk_rd(8'h05, 8'h00);
    // Every writable user register gets a value before the store
    for (int r = 0; r <= 26; r++)
      if (r != 23 && r != 24)
        HOST.wr(`LMD_I2C_ADDR, 8'(r), 8'(r) ^ 8'h3C, ok);
    for (int i = 0; i < 4; i++)
      chk_rd(ra[i], ra[i] ^ 8'h3C);
    HOST.wr(`LMD_I2C_ADDR, `LMD_FAULT_REG, 8'hFF, ok);
    `CHK(ok, 1'b1)
    chk_rd(`LMD_FAULT_REG, 8'h00);
    HOST.wr(7'h37, 8'h00, 8'h77, ok);
    `CHK(ok, 1'b0)
    chk_rd(8'h00, 8'h3C);
    store_req <= 1'b1;
    cyc(4);
    store_req <= 1'b0;
    cyc(4);
    HOST.wr(`LMD_I2C_ADDR, 8'h03, 8'h11, ok);
    chk_rd(8'h03, 8'h11);
    en <= 1'b0;
    cyc(6);
    `CHK({led_drive, conv_on, standby}, 5'b000_0_0)
    en <= 1'b1;
    cyc(6);
    chk_rd(8'h03, 8'h3F);
    chk_rd(8'h1A, 8'h26);
    chan(3'b010, 5'b010_1_0);
    chan(3'b110, 5'b010_1_0);
    chan(3'b000, 5'b000_0_1);
    chan(3'b101, 5'b100_1_0);
    chan(3'b001, 5'b001_1_0);
    en <= 1'b0;
    chan(3'b001, 5'b000_0_0);
    en <= 1'b1;
    chan(3'b000, 5'b000_0_1);
    for (int i = 0; i < 3; i++)
    begin
      fault_det <= 3'(1 << i);
      cyc(6);
      fault_det <= 3'b000;
      cyc(6);
      `CHK({fault_flags, fault_oe_n}, {3'(1 << i), 1'b0})
      chk_rd(`LMD_FAULT_REG, 8'(1 << i));
      `CHK({fault_flags, fault_oe_n}, 4'b000_1)
    end
    end_of_test();
  end
endmodule // tb_lmd_ctrl
